// *** pkg/switch_cfg_pkg.sv ***
// constants and carrier types for the switch PHY and MAC configuration bank
// assumes one 125 MHz clock and a management engine that issues one request per cycle
package switch_cfg_pkg;

  // ----------------------------------------------------------------
  // sizes and clock
  // ----------------------------------------------------------------
  localparam int NUM_PHY_PORTS = 5;
  localparam int MCLK_PERIOD_NS = 8;

  // ----------------------------------------------------------------
  // global register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_SPI_EDGE = 16'h0100;
  localparam logic [15:0] OFS_MAC_BP = 16'h0331;
  localparam logic [15:0] OFS_TUNE_A = 16'h03C0;
  localparam logic [15:0] OFS_TUNE_B = 16'h03C2;
  localparam logic [15:0] OFS_TUNE_C = 16'h03C4;
  localparam logic [15:0] OFS_P6_RGMII = 16'h6301;

  // ----------------------------------------------------------------
  // per-port offsets and PHY register indices
  // ----------------------------------------------------------------
  localparam logic [5:0] PHY_WIN_BLOCK = 6'h04;
  localparam logic [11:0] OFS_PORT_FLOW = 12'h403;
  localparam logic [4:0] PHY_UPPER_FIRST = 5'h10;
  localparam logic [4:0] REG_BASIC_CTRL = 5'h00;
  localparam logic [4:0] REG_MMD_SETUP = 5'h0D;
  localparam logic [4:0] REG_MMD_DATA = 5'h0E;
  localparam logic [4:0] MMD_DEV_EEE = 5'h07;
  localparam logic [15:0] MMD_EEE_ADV_REG = 16'h003C;
  localparam logic [15:0] EEE_ADV_MASK = 16'h0006;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_POWER_DOWN = 11;
  localparam int BIT_AN_ENABLE = 12;
  localparam int BIT_SPI_AUTO = 1;
  localparam int BIT_SPI_MANUAL = 0;
  localparam int BIT_BP_CARRIER = 5;
  localparam int BIT_RGMII_RX_DLY = 4;
  localparam int BIT_FLOW_EN = 3;

  // ----------------------------------------------------------------
  // values after reset and pause repair values
  // ----------------------------------------------------------------
  localparam logic [15:0] BASIC_CTRL_RESET = 16'h1140;
  localparam logic [15:0] EEE_ADV_RESET = 16'h0006;
  localparam logic [7:0] SPI_EDGE_RESET = 8'h02;
  localparam logic [7:0] MAC_BP_RESET = 8'h20;
  localparam logic [7:0] RGMII_RESET = 8'h00;
  localparam logic [7:0] FLOW_RESET = 8'h00;
  localparam logic [15:0] TUNE_RESET = 16'h0000;
  localparam logic [15:0] PAUSE_FIX_A = 16'h4090;
  localparam logic [15:0] PAUSE_FIX_B = 16'h0080;
  localparam logic [15:0] PAUSE_FIX_C = 16'h2000;

  // ----------------------------------------------------------------
  // serial clock rate sensing
  // ----------------------------------------------------------------
  localparam int SPI_FAST_PERIOD_NS = 40;
  localparam logic [7:0] SPI_FAST_CYCLES = 8'(SPI_FAST_PERIOD_NS / MCLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SIZE_8, SIZE_16, SIZE_32} access_size_t;
  typedef enum logic [2:0] {T_NONE, T_SPI, T_BP, T_TUNE_A, T_TUNE_B, T_TUNE_C, T_RGMII, T_PHY_FLOW} target_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic viaMdio;
    access_size_t size;
    logic [15:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } reg_rsp_t;

endpackage

// *** rtl/phy_reg_window.sv ***
// per-port PHY register window storage, 32 half-words per port
// assumes the caller presents at most one write per cycle and aligned 32-bit accesses
`timescale 1ns/100ps
module phy_reg_window #(
  parameter int PORTS = switch_cfg_pkg::NUM_PHY_PORTS
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic wrEn,
  input wire logic [2:0] port,
  input wire logic [4:0] idx,
  input wire logic byteLo,
  input wire switch_cfg_pkg::access_size_t size,
  input wire logic [31:0] wdata,
  output logic [31:0] rdPair,
  output logic [PORTS-1:0][15:0] basicCtrl,
  output logic [PORTS-1:0][15:0] mmdSetup
);
  import switch_cfg_pkg::*;

  typedef struct packed {
    logic [PORTS*32-1:0][15:0] mem;
  } win_state_t;

  win_state_t state;
  win_state_t next_state;
  logic [7:0] evenIdx;
  logic [7:0] oddIdx;
  logic [7:0] curIdx;
  logic [31:0] pair;

  assign evenIdx = {port, idx[4:1], 1'b0};
  assign oddIdx = {port, idx[4:1], 1'b1};
  assign curIdx = {port, idx};
  assign rdPair = {state.mem[evenIdx], state.mem[oddIdx]};

  always_comb
  begin
    for (int p = 0; p < PORTS; p++)
    begin
      basicCtrl[p] = state.mem[p*32 + 0];
      mmdSetup[p] = state.mem[p*32 + 13];
    end
  end

  always_comb
  begin
    next_state = state;
    pair = 32'h00000000;
    if (reset)
    begin
      next_state = '0;
      for (int p = 0; p < PORTS; p++)
        next_state.mem[p*32] = BASIC_CTRL_RESET;
    end
    else if (wrEn && idx >= PHY_UPPER_FIRST)
    begin
      // upper half: every write lands on the whole pair, unwritten lanes as zero
      case (size) // RL3
        SIZE_32: pair = wdata;
        SIZE_16: pair = idx[0] ? {16'h0000, wdata[15:0]} : {wdata[15:0], 16'h0000};
        SIZE_8: pair = 32'({24'h000000, wdata[7:0]} << {~{idx[0], byteLo}, 3'b000});
        default: pair = 32'h00000000;
      endcase
      next_state.mem[evenIdx] = pair[31:16]; // RL22
      next_state.mem[oddIdx] = pair[15:0]; // RL22
    end
    else if (wrEn)
    begin
      // lower half: only the bytes written change
      case (size) // RL2
        SIZE_32:
        begin
          next_state.mem[evenIdx] = wdata[31:16];
          next_state.mem[oddIdx] = wdata[15:0];
        end
        SIZE_16: next_state.mem[curIdx] = wdata[15:0];
        SIZE_8:
        begin
          if (byteLo)
            next_state.mem[curIdx][7:0] = wdata[7:0];
          else
            next_state.mem[curIdx][15:8] = wdata[7:0];
        end
        default: next_state.mem[curIdx] = state.mem[curIdx];
      endcase
    end
  end

  always_ff @(posedge mclk)
    state <= next_state;

  a_pair_zero_fill: assert property (@(posedge mclk) disable iff (reset) // RL3
    (wrEn && idx >= PHY_UPPER_FIRST && size == SIZE_16 && idx[0])
    |=> state.mem[$past(evenIdx)] == 16'h0000)
    else $error("upper 16-bit write left partner half non-zero");

  a_pair_atomic: assert property (@(posedge mclk) disable iff (reset) // RL22
    (wrEn && idx >= PHY_UPPER_FIRST && size == SIZE_32)
    |=> {state.mem[$past(evenIdx)], state.mem[$past(oddIdx)]} == $past(wdata))
    else $error("32-bit pair write did not land in both halves");

  a_byte_keep: assert property (@(posedge mclk) disable iff (reset) // RL2
    (wrEn && idx < PHY_UPPER_FIRST && size == SIZE_8 && byteLo)
    |=> state.mem[$past(curIdx)][15:8] == $past(state.mem[curIdx][15:8]))
    else $error("lower byte write disturbed the upper byte");

  a_read_quiet: assert property (@(posedge mclk) disable iff (reset) // RL4
    !wrEn |=> $stable(state.mem))
    else $error("window contents changed without a write");

endmodule

// *** rtl/spi_edge_sense.sv ***
// one-shot serial clock rate sensing that picks the output launch edge
// assumes sclk is already synchronous to mclk; measures once after reset
`timescale 1ns/100ps
module spi_edge_sense (
  input wire logic mclk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic autoEn,
  output logic measuredEdge,
  output logic locked
);
  import switch_cfg_pkg::*;

  typedef enum logic [1:0] {WAIT_RISE, COUNT, LOCKED} sense_mode_t;

  typedef struct packed {
    sense_mode_t mode;
    logic sclkPrev;
    logic [7:0] period;
    logic edgeSel;
  } sense_state_t;

  sense_state_t state;
  sense_state_t next_state;
  logic rise;

  assign rise = sclk && !state.sclkPrev;
  assign measuredEdge = state.edgeSel;
  assign locked = state.mode == LOCKED;

  always_comb
  begin
    next_state = state;
    next_state.sclkPrev = sclk;
    case (state.mode)
      WAIT_RISE:
      begin
        next_state.period = 8'h00;
        if (autoEn && rise)
          next_state.mode = COUNT;
      end
      COUNT:
      begin
        if (state.period != 8'hFF)
          next_state.period = state.period + 8'h01;
        if (rise)
        begin
          // fast clock launches on the rising edge, slow on the falling
          next_state.edgeSel = state.period < SPI_FAST_CYCLES; // RL13
          next_state.mode = LOCKED;
        end
      end
      LOCKED: next_state.mode = LOCKED;
      default: next_state.mode = WAIT_RISE;
    endcase
    if (reset)
      next_state = '{mode: WAIT_RISE, sclkPrev: 1'b0, period: 8'h00, edgeSel: 1'b0};
  end

  always_ff @(posedge mclk)
    state <= next_state;

  a_edge_once: assert property (@(posedge mclk) disable iff (reset) // RL13
    locked |=> locked && $stable(measuredEdge))
    else $error("serial edge choice changed after it was locked");

endmodule

// *** rtl/switch_phy_config_regs.sv ***
// management register bank: PHY windows, EEE advertisement, port 6 delay, serial edge, back-pressure, rate flow control
// assumes requests arrive as one-cycle strobes on mclk from the serial, in-band or MDIO engines
//
// Overview of operation
// (RL1) Each port's PHY registers sit at byte offsets N100 to N13F.
// (RL2) Lower window N100-N11F takes byte and half-word writes, changing only written bytes.
// (RL3) Upper window N120-N13F writes whole pairs; unwritten half of pair becomes zero.
// (RL4) Window reads return stored contents and change nothing.
// (RL5) Software writes upper pairs as 32 bits after read-merge, never assuming zeros.
// (RL6) Basic control bit 11 powers down that one PHY; clearing powers it up.
// (RL7) Software changes power-down only while no other PHY carries traffic.
// (RL8) EEE advertisement is on for every port after reset.
// (RL9) Clearing MMD 7 register 0x3C bits 2:1 stops EEE advertisement on that port.
// (RL10) EEE activates only when both partners negotiate it, never without auto-negotiation.
// (RL11) After EEE change software writes 0x1340 to basic control to restart negotiation.
// (RL12) Bit 4 of port6_rgmii_delay_control adds receive delay on the port 6 RGMII input.
// (RL13) Automatic serial edge measures the clock once and never re-adapts.
// (RL14) Clearing bit 1 of spi_edge_control disables automatic edge; bit 0 picks the edge.
// (RL15) Above 15 MHz software clears auto and sets the manual edge in one write.
// (RL16) Bit 5 of mac_backpressure_control selects carrier back-pressure when set, collision when clear.
// (RL17) Register mac_backpressure_control is reachable from serial, I2C and in-band paths, not MDIO.
// (RL18) With flow enable in N403, over-limit frames are paused, not dropped.
// (RL19) Writing 0x4090, 0x0080, 0x2000 to hidden_pause_tuning_a/2/4 restores pause on EEE links.
// (RL20) Software writes the power-tuning values to MMD 0x1C registers 0x13 to 0x20.
// (RL21) Before MMD setup software writes 0x2100 to basic control, forcing 100M full.
// (RL22) A 32-bit upper window write updates both halves in one transaction.
`timescale 1ns/100ps
module switch_phy_config_regs #(
  parameter int PORTS = switch_cfg_pkg::NUM_PHY_PORTS
) (
  input wire logic mclk,
  input wire logic reset,
  input wire switch_cfg_pkg::reg_req_t regReq,
  output switch_cfg_pkg::reg_rsp_t regRsp,
  input wire logic [PORTS-1:0] linkUp,
  input wire logic [PORTS-1:0] partnerEee,
  input wire logic [PORTS-1:0] rateExceeded,
  input wire logic spiSclk,
  output logic [PORTS-1:0] phyPowerDown,
  output logic [PORTS-1:0] eeeActive,
  output logic [PORTS-1:0] pauseRequest,
  output logic [PORTS-1:0] dropFrame,
  output logic rgmiiRxDelayEn,
  output logic spiOutEdge,
  output logic backpressureCarrier
);
  import switch_cfg_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] spiEdgeCtl;
    logic [7:0] macBp;
    logic [15:0] tuneA;
    logic [15:0] tuneB;
    logic [15:0] tuneC;
    logic [7:0] rgmiiDly;
    logic [PORTS-1:0][7:0] flowCtl;
    logic [PORTS-1:0][15:0] eeeAdv;
    logic [PORTS-1:0][15:0] mmdAddr;
    reg_rsp_t rsp;
    logic [PORTS-1:0] powerDown;
    logic [PORTS-1:0] eeeOn;
    logic [PORTS-1:0] pause;
    logic [PORTS-1:0] drop;
    logic rxDelay;
    logic outEdge;
    logic bpCarrier;
  } cfg_state_t;

  cfg_state_t state;
  cfg_state_t next_state;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic portOk(input logic [15:0] a);
    portOk = a[15:12] != 4'h0 && 32'(a[15:12]) <= PORTS;
  endfunction

  function automatic target_t decode(input logic [15:0] a);
    if (a == OFS_SPI_EDGE)
      decode = T_SPI;
    else if (a == OFS_MAC_BP)
      decode = T_BP;
    else if (a == OFS_TUNE_A)
      decode = T_TUNE_A;
    else if (a == OFS_TUNE_B)
      decode = T_TUNE_B;
    else if (a == OFS_TUNE_C)
      decode = T_TUNE_C;
    else if (a == OFS_P6_RGMII)
      decode = T_RGMII;
    else if (portOk(a) && (a[11:6] == PHY_WIN_BLOCK || a[11:0] == OFS_PORT_FLOW))
      decode = T_PHY_FLOW;
    else
      decode = T_NONE;
  endfunction

  target_t tgt;
  logic [2:0] pIdx;
  logic [4:0] rIdx;
  logic inWindow;
  logic winWr;
  logic [31:0] rdPair;
  logic [15:0] rdHalf;
  logic [31:0] rdValue;
  logic [PORTS-1:0][15:0] basicCtrl;
  logic [PORTS-1:0][15:0] mmdSetup;
  logic mmdDataAccess;
  logic mmdIsEee;
  logic [15:0] mmdValue;
  logic [PORTS-1:0] anVec;
  logic [PORTS-1:0] flowVec;
  logic pauseFixApplied;
  logic measuredEdge;
  logic edgeLocked;
  logic advAllDefault;

  assign tgt = decode(regReq.addr);
  assign pIdx = 3'(regReq.addr[15:12] - 4'h1);
  assign rIdx = regReq.addr[5:1];
  assign inWindow = tgt == T_PHY_FLOW && regReq.addr[11:6] == PHY_WIN_BLOCK; // RL1
  assign winWr = regReq.valid && regReq.write && inWindow;
  assign mmdDataAccess = inWindow && rIdx == REG_MMD_DATA && regReq.size == SIZE_16;
  assign mmdIsEee = mmdSetup[pIdx][4:0] == MMD_DEV_EEE && state.mmdAddr[pIdx] == MMD_EEE_ADV_REG;
  assign mmdValue = mmdIsEee ? state.eeeAdv[pIdx] : 16'h0000;

  // ----------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------
  phy_reg_window #(.PORTS(PORTS)) u_window (
    .mclk(mclk),
    .reset(reset),
    .wrEn(winWr),
    .port(pIdx),
    .idx(rIdx),
    .byteLo(regReq.addr[0]),
    .size(regReq.size),
    .wdata(regReq.wdata),
    .rdPair(rdPair),
    .basicCtrl(basicCtrl),
    .mmdSetup(mmdSetup)
  );

  spi_edge_sense u_edge (
    .mclk(mclk),
    .reset(reset),
    .sclk(spiSclk),
    .autoEn(state.spiEdgeCtl[BIT_SPI_AUTO]),
    .measuredEdge(measuredEdge),
    .locked(edgeLocked)
  );

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb
  begin
    rdHalf = regReq.addr[1] ? rdPair[15:0] : rdPair[31:16];
    rdValue = 32'h00000000;
    case (tgt)
      T_SPI: rdValue = {24'h000000, state.spiEdgeCtl};
      T_BP: rdValue = regReq.viaMdio ? 32'h00000000 : {24'h000000, state.macBp}; // RL17
      T_TUNE_A: rdValue = {16'h0000, state.tuneA};
      T_TUNE_B: rdValue = {16'h0000, state.tuneB};
      T_TUNE_C: rdValue = {16'h0000, state.tuneC};
      T_RGMII: rdValue = {24'h000000, state.rgmiiDly};
      T_PHY_FLOW:
      begin
        if (!inWindow)
          rdValue = {24'h000000, state.flowCtl[pIdx]};
        else if (mmdDataAccess && mmdSetup[pIdx][15:14] != 2'b00)
          rdValue = {16'h0000, mmdValue};
        else
        begin
          // reads have no side effect on stored contents
          case (regReq.size) // RL4
            SIZE_32: rdValue = rdPair;
            SIZE_16: rdValue = {16'h0000, rdHalf};
            SIZE_8: rdValue = {24'h000000, regReq.addr[0] ? rdHalf[7:0] : rdHalf[15:8]};
            default: rdValue = 32'h00000000;
          endcase
        end
      end
      default: rdValue = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // status derivation
  // ----------------------------------------------------------------
  always_comb
  begin
    advAllDefault = 1'b1;
    for (int p = 0; p < PORTS; p++)
    begin
      anVec[p] = basicCtrl[p][BIT_AN_ENABLE];
      flowVec[p] = state.flowCtl[p][BIT_FLOW_EN];
      advAllDefault = advAllDefault && state.eeeAdv[p] == EEE_ADV_RESET;
    end
  end

  // pause repair is only in force once all three values are present
  assign pauseFixApplied = state.tuneA == PAUSE_FIX_A && state.tuneB == PAUSE_FIX_B // RL19
    && state.tuneC == PAUSE_FIX_C;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_state.rsp.ack = 1'b0;
    if (regReq.valid)
    begin
      next_state.rsp.ack = 1'b1;
      next_state.rsp.rdata = regReq.write ? 32'h00000000 : rdValue;
    end
    if (regReq.valid && regReq.write)
    begin
      case (tgt)
        T_SPI: next_state.spiEdgeCtl = regReq.wdata[7:0]; // RL14
        T_BP:
        begin
          if (!regReq.viaMdio) // RL17
            next_state.macBp = regReq.wdata[7:0];
        end
        T_TUNE_A: next_state.tuneA = regReq.wdata[15:0];
        T_TUNE_B: next_state.tuneB = regReq.wdata[15:0];
        T_TUNE_C: next_state.tuneC = regReq.wdata[15:0];
        T_RGMII: next_state.rgmiiDly = regReq.wdata[7:0];
        T_PHY_FLOW:
        begin
          if (!inWindow)
            next_state.flowCtl[pIdx] = regReq.wdata[7:0];
          else if (mmdDataAccess && mmdSetup[pIdx][15:14] == 2'b00)
            next_state.mmdAddr[pIdx] = regReq.wdata[15:0];
          else if (mmdDataAccess && mmdIsEee)
            next_state.eeeAdv[pIdx] = regReq.wdata[15:0] & EEE_ADV_MASK; // RL9
        end
        default: next_state.spiEdgeCtl = state.spiEdgeCtl;
      endcase
    end
    for (int p = 0; p < PORTS; p++)
    begin
      next_state.powerDown[p] = basicCtrl[p][BIT_POWER_DOWN]; // RL6
      // negotiated only: needs auto-negotiation, own advert, partner ability and link
      next_state.eeeOn[p] = anVec[p] && linkUp[p] && partnerEee[p] // RL10
        && (state.eeeAdv[p] & EEE_ADV_MASK) != 16'h0000 && !basicCtrl[p][BIT_POWER_DOWN]; // RL9
      next_state.pause[p] = rateExceeded[p] && flowVec[p] && (!state.eeeOn[p] || pauseFixApplied); // RL18
      next_state.drop[p] = rateExceeded[p] && !flowVec[p]; // RL18
    end
    next_state.rxDelay = state.rgmiiDly[BIT_RGMII_RX_DLY]; // RL12
    next_state.bpCarrier = state.macBp[BIT_BP_CARRIER]; // RL16
    next_state.outEdge = state.spiEdgeCtl[BIT_SPI_AUTO] ? measuredEdge // RL13
      : state.spiEdgeCtl[BIT_SPI_MANUAL]; // RL14
    if (reset)
    begin
      next_state = '0;
      next_state.spiEdgeCtl = SPI_EDGE_RESET;
      next_state.macBp = MAC_BP_RESET;
      next_state.tuneA = TUNE_RESET;
      next_state.tuneB = TUNE_RESET;
      next_state.tuneC = TUNE_RESET;
      next_state.rgmiiDly = RGMII_RESET;
      for (int p = 0; p < PORTS; p++)
      begin
        next_state.flowCtl[p] = FLOW_RESET;
        next_state.eeeAdv[p] = EEE_ADV_RESET; // RL8
      end
    end
  end

  always_ff @(posedge mclk)
    state <= next_state;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regRsp = state.rsp;
  assign phyPowerDown = state.powerDown;
  assign eeeActive = state.eeeOn;
  assign pauseRequest = state.pause;
  assign dropFrame = state.drop;
  assign rgmiiRxDelayEn = state.rxDelay;
  assign spiOutEdge = state.outEdge;
  assign backpressureCarrier = state.bpCarrier;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_powerdown_follows: assert property (@(posedge mclk) disable iff (reset) // RL6
    ##1 phyPowerDown[0] == $past(basicCtrl[0][BIT_POWER_DOWN]))
    else $error("power-down output does not follow basic control bit");

  a_eee_needs_an: assert property (@(posedge mclk) disable iff (reset) // RL10
    ##1 (eeeActive & ~$past(anVec)) == '0)
    else $error("EEE active without auto-negotiation");

  a_eee_default: assert property (@(posedge mclk) // RL8
    $fell(reset) |-> advAllDefault)
    else $error("EEE advertisement not on after reset");

  a_mdio_bp_block: assert property (@(posedge mclk) disable iff (reset) // RL17
    (regReq.valid && regReq.write && regReq.viaMdio && tgt == T_BP) |=> $stable(state.macBp))
    else $error("back-pressure register written over MDIO");

  a_rgmii_delay: assert property (@(posedge mclk) disable iff (reset) // RL12
    (regReq.valid && regReq.write && tgt == T_RGMII) |-> ##2 rgmiiRxDelayEn == $past(regReq.wdata[4], 2))
    else $error("port 6 receive delay does not follow its register");

  a_flow_no_drop: assert property (@(posedge mclk) disable iff (reset) // RL18
    ##1 (dropFrame & $past(flowVec)) == '0)
    else $error("frame dropped while rate flow control enabled");

  a_spi_manual: assert property (@(posedge mclk) disable iff (reset) // RL14
    !state.spiEdgeCtl[BIT_SPI_AUTO] |=> spiOutEdge == $past(state.spiEdgeCtl[BIT_SPI_MANUAL]))
    else $error("manual serial edge not applied");

  a_bp_mode: assert property (@(posedge mclk) disable iff (reset) // RL16
    $changed(state.macBp[BIT_BP_CARRIER]) |=> backpressureCarrier == $past(state.macBp[BIT_BP_CARRIER]))
    else $error("back-pressure mode does not follow bit 5");

  a_edge_stable: assert property (@(posedge mclk) disable iff (reset) // RL13
    (edgeLocked && state.spiEdgeCtl[BIT_SPI_AUTO]) [*2] |-> $stable(measuredEdge))
    else $error("automatic serial edge re-adapted");

endmodule

// *** test/mgmt_host_model.sv ***
// host model: issues register requests and drives the serial clock
// assumes switch_cfg_pkg is compiled first; one request in flight
`timescale 1ns/100ps
module mgmt_host_model (
  input wire logic mclk,
  output switch_cfg_pkg::reg_req_t regReq,
  input wire switch_cfg_pkg::reg_rsp_t regRsp,
  output logic spiSclk
);
  import switch_cfg_pkg::*;
  logic [31:0] rd;
  logic ok;
  initial regReq = '0;
  initial spiSclk = 1'b0;
  task automatic acc(input logic w, input logic m, input access_size_t s, input logic [15:0] a,
    input logic [31:0] d);
    @(posedge mclk);
    regReq <= '{1'b1, w, m, s, a, d};
    @(posedge mclk);
    regReq.valid <= 1'b0;
    #1;
    ok = regRsp.ack;
    rd = regRsp.rdata;
  endtask
  // serial clock toggles six times, h mclk cycles apart
  task automatic sclk(input int h);
    repeat (6)
    begin
      repeat (h) @(posedge mclk);
      spiSclk <= ~spiSclk;
    end
  endtask
endmodule

// *** test/switch_phy_config_regs_tb_top.sv ***
// self-checking bench for the switch configuration bank
// assumes the design asserts its own rules inside its files
`timescale 1ns/100ps
module switch_phy_config_regs_tb_top;
  import switch_cfg_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] linkUp = '1, partnerEee = '1, rateExceeded = '0, pd, ea, pr, dr;
  logic rg, se, bp, spiSclk;
  logic [7:0] r = 8'h26;
  logic [15:0] tuneVal [13] = '{16'h6EFF, 16'hE6FF, 16'h6EFF, 16'hE6FF, 16'h00FF, 16'h43FF, 16'hC3FF,
    16'h6FFF, 16'h07FF, 16'h0FFF, 16'hE7FF, 16'hEFFF, 16'hEEEE};
  reg_req_t regReq;
  reg_rsp_t regRsp;
  int n_errors = 0;
  int tests_run = 0;
  always #4 mclk = ~mclk;
  mgmt_host_model mgmt_host_model_i (.mclk(mclk), .regReq(regReq), .regRsp(regRsp), .spiSclk(spiSclk));
  switch_phy_config_regs #(.PORTS(5)) switch_phy_config_regs_i (.mclk(mclk), .reset(reset),
    .regReq(regReq), .regRsp(regRsp), .linkUp(linkUp), .partnerEee(partnerEee),
    .rateExceeded(rateExceeded), .spiSclk(spiSclk), .phyPowerDown(pd), .eeeActive(ea),
    .pauseRequest(pr), .dropFrame(dr), .rgmiiRxDelayEn(rg), .spiOutEdge(se), .backpressureCarrier(bp));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // ports 1 and 3 have flow control on
  function automatic logic [4:0] lim(input logic [4:0] x, input logic p);
    return p ? (x & 5'h05) : (x & 5'h1A);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [15:0] a, input logic [31:0] d, input access_size_t s = SIZE_16);
    mgmt_host_model_i.acc(1'b1, 1'b0, s, a, d);
    chk(mgmt_host_model_i.ok, 1);
  endtask
  task automatic rdc(input logic [15:0] a, input access_size_t s, input logic [31:0] e);
    mgmt_host_model_i.acc(1'b0, 1'b0, s, a, 0);
    chk(mgmt_host_model_i.rd, e);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_errors++;
    summarize();
  end
  initial
  begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    mgmt_host_model_i.sclk(2);
    step(3);
    chk(se, 1);
    mgmt_host_model_i.sclk(8);
    step(3);
    chk(se, 1);
    chk(ea, 5'h1F);
    chk(bp, 1);
    rdc(OFS_SPI_EDGE, SIZE_8, 32'h02);
    w(OFS_SPI_EDGE, 32'h00, SIZE_8);
    step(1);
    chk(se, 0);
    $display("edge and reset test done");
    w(16'h2100, 32'h2100);
    w(16'h211A, 32'h0007);
    w(16'h211C, 32'h003C);
    w(16'h211A, 32'h4007);
    rdc(16'h211C, SIZE_16, 32'h0006);
    w(16'h211C, 32'h0000);
    foreach (tuneVal[i])
    begin
      w(16'h211A, 32'h001C);
      w(16'h211C, 32'(16'h13 + i + (i == 12)));
      w(16'h211A, 32'h401C);
      w(16'h211C, {16'h0000, tuneVal[i]});
    end
    w(16'h2100, 32'h1340);
    step(1);
    chk(ea, 5'h1D);
    @(posedge mclk);
    linkUp <= 5'h01;
    w(16'h1100, 32'h08, SIZE_8);
    @(posedge mclk);
    linkUp <= '1;
    step(2);
    chk(pd, 5'h01);
    chk(ea, 5'h1C);
    rdc(16'h1100, SIZE_16, 32'h0840);
    w(16'h1101, 32'h00, SIZE_8);
    rdc(16'h1100, SIZE_16, 32'h0800);
    $display("eee and power test done");
    rdc(16'h3120, SIZE_32, 32'h00000000);
    w(16'h3120, 32'h12345678, SIZE_32);
    rdc(16'h3120, SIZE_32, 32'h12345678);
    w(16'h3122, 32'hABCD);
    repeat (2) rdc(16'h3120, SIZE_32, 32'h0000ABCD);
    w(16'h3121, 32'h5A, SIZE_8);
    rdc(16'h3120, SIZE_32, 32'h005A0000);
    $display("window test done");
    mgmt_host_model_i.acc(1'b1, 1'b1, SIZE_8, OFS_MAC_BP, 32'hD0);
    rdc(OFS_MAC_BP, SIZE_8, 32'h20);
    w(OFS_MAC_BP, 32'hD0, SIZE_8);
    w(OFS_P6_RGMII, 32'h10, SIZE_8);
    step(1);
    chk(bp, 0);
    chk(rg, 1);
    w(16'h1403, 32'h08, SIZE_8);
    w(16'h3403, 32'h08, SIZE_8);
    @(posedge mclk);
    rateExceeded <= '1;
    step(2);
    chk(pr, 5'h01);
    chk(dr, 5'h1A);
    w(OFS_TUNE_A, PAUSE_FIX_A);
    w(OFS_TUNE_B, PAUSE_FIX_B);
    w(OFS_TUNE_C, PAUSE_FIX_C);
    step(1);
    chk(pr, 5'h05);
    repeat (12)
    begin
      r = lfsr(r);
      @(posedge mclk);
      rateExceeded <= r[4:0];
      step(2);
      chk(pr, lim(r[4:0], 1'b1));
      chk(dr, lim(r[4:0], 1'b0));
    end
    $display("flow test done");
    summarize();
  end
endmodule
